// ---- core/pin_mux_params.svh ----
// Offsets, field positions, reset values and timing counts of the pin mux
`ifndef PIN_MUX_PARAMS_SVH
`define PIN_MUX_PARAMS_SVH
`define OFS_BUFCFG 8'h00
`define OFS_PHASE 8'h04
`define OFS_GAIN 8'h08
`define OFS_ATEST 8'h0c
`define OFS_PERIOD 8'h10
`define OFS_STATUS 8'h14
`define OFS_CAL0 8'h18
`define OFS_CAL1 8'h1c
`define ROLE_LSB 0
`define TSEL_LSB 8
`define BENCH_BIT 0
`define STAT_LOCK_BIT 0
`define STAT_SWCLK_BIT 1
`define STAT_MEAS_LSB 16
`define ROLE_CODE_STANDALONE 3'h0
`define ROLE_CODE_MP_MASTER 3'h1
`define ROLE_CODE_MP_SLAVE 3'h2
`define ROLE_CODE_MO_MASTER 3'h3
`define ROLE_CODE_MO_SLAVE 3'h4
`define RST_ROLE 3'h0
`define RST_TSEL 5'h00
`define RST_PHASE 8'h00
`define RST_GAIN 4'h0
`define RST_BENCH 1'b0
`define CLK_KHZ 40000
`define SW_FREQ_KHZ 300
`define SW_PERIOD_CYC (`CLK_KHZ / `SW_FREQ_KHZ)
`define GAIN_UNITY 5'h08
`define GAIN_SHIFT 3
`define LOCK_EDGES 2'h2
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ---- core/pin_mux_pkg.sv ----
// Types shared by the pin mux modules
package pin_mux_pkg;
  typedef enum logic [4:0] {
    ROLE_STANDALONE = 5'h01,
    ROLE_MP_MASTER = 5'h02,
    ROLE_MP_SLAVE = 5'h04,
    ROLE_MO_MASTER = 5'h08,
    ROLE_MO_SLAVE = 5'h10
  } role_t;
endpackage : pin_mux_pkg

// ---- core/sync_link_if.sv ----
// Signals between the pin mux control and the phase lock
`timescale 1ns/1ps
interface sync_link_if #(parameter int PW = 16, parameter int OW = 8);
  logic master_edge;
  logic slave_mode;
  logic [PW-1:0] period_cfg;
  logic [OW-1:0] phase_off;
  logic sw_clk;
  logic locked;
  logic [PW-1:0] meas_period;
  modport ctrl (output master_edge, output slave_mode, output period_cfg,
    output phase_off, input sw_clk, input locked, input meas_period);
  modport lock (input master_edge, input slave_mode, input period_cfg,
    input phase_off, output sw_clk, output locked, output meas_period);
endinterface : sync_link_if

// ---- core/phase_lock.sv ----
// Switching clock generator that locks to a master clock with phase offset
`timescale 1ns/1ps
`include "pin_mux_params.svh"
module phase_lock #(
  parameter int PW = 16,
  parameter int OW = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  sync_link_if.lock lnk
);
  if (PW < 4 || OW < 1 || OW > PW) begin : g_bad_width
    $error("phase_lock: unsupported widths");
  end

  logic [PW-1:0] cnt_r, gap_r, meas_r, dly_r, eff, since_r;
  logic dly_act_r, restart;
  logic [1:0] edges_r;

  // Measured period only once two master edges framed it
  assign lnk.locked = (edges_r == `LOCK_EDGES);
  assign lnk.meas_period = meas_r;
  always_comb begin
    eff = (lnk.slave_mode && lnk.locked) ? meas_r : lnk.period_cfg;
    if (eff < PW'(2)) begin
      eff = PW'(2);
    end
  end
  assign restart = dly_act_r && (dly_r == '0);
  assign lnk.sw_clk = (cnt_r < (eff >> 1));

  // Master period measurement, saturating so a dead master cannot wrap
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !lnk.slave_mode) begin
      gap_r <= '0;
      meas_r <= '0;
      edges_r <= 2'h0;
    end else if (lnk.master_edge) begin
      meas_r <= gap_r + PW'(1);
      gap_r <= '0;
      if (edges_r != `LOCK_EDGES) begin
        edges_r <= edges_r + 2'h1;
      end
    end else if (gap_r != '1) begin
      gap_r <= gap_r + PW'(1);
    end
  end

  // Phase delay from each master edge to the local cycle start
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || !lnk.slave_mode) begin
      dly_act_r <= 1'b0;
      dly_r <= '0;
    end else if (lnk.master_edge) begin
      dly_r <= PW'(lnk.phase_off);
      dly_act_r <= 1'b1;
    end else if (dly_act_r) begin
      if (dly_r == '0) begin
        dly_act_r <= 1'b0;
      end else begin
        dly_r <= dly_r - PW'(1);
      end
    end
  end

  // Local switching counter; free running unless a slave restart lands
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      cnt_r <= '0;
    end else if (restart) begin
      cnt_r <= '0;
    end else if (cnt_r >= eff - PW'(1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + PW'(1);
    end
  end

  // Cycles since the last master edge, read only by checks
  always_ff @(posedge i_clk_sys) begin
    if (i_rst || lnk.master_edge) begin
      since_r <= '0;
    end else if (since_r != '1) begin
      since_r <= since_r + PW'(1);
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_phase_delay;
    (restart && lnk.slave_mode && !$past(lnk.master_edge, 1)) |->
      (since_r == PW'(lnk.phase_off));
  endproperty
  a_phase_delay: assert property (p_phase_delay)
    else $error("slave cycle start not at programmed phase");

  property p_free_run;
    (!lnk.slave_mode && lnk.period_cfg >= PW'(2) && $stable(lnk.period_cfg)
      && cnt_r == lnk.period_cfg - PW'(1)) |=> (cnt_r == '0);
  endproperty
  a_free_run: assert property (p_free_run)
    else $error("free running period wrong");
endmodule : phase_lock

// ---- core/multiphase_sync_pin_mux.sv ----
// Master/slave pin routing, error gain and bench test mux with AXI4-Lite
`timescale 1ns/1ps
`include "pin_mux_params.svh"
// Behaviour
// - Three-bit role field selects converter role
// - Multi-phase master drives switching clock out
// - Multi-phase master drives error amp out
// - Multi-phase slave locks to incoming clock
// - Slave delays cycle by phase offset
// - Multi-phase slave takes error pin as input
// - Multi-phase slave scales received error by gain setting
// - Multi-phase slave regulates from scaled master error
// - Multiple-output master drives clock pin out
// - Multiple-output slave syncs; error pin unused
// - Bench enable puts test output on debug
// - Five-bit select picks debug test signal
// - Calibration words never writable
module multiphase_sync_pin_mux #(
  parameter int ERR_W = 10,
  parameter int PW = 16,
  parameter int OW = 8,
  parameter logic [31:0] CAL0_VAL = 32'h0000_1234, // Arbitrary value
  parameter logic [31:0] CAL1_VAL = 32'h0000_5678 // Arbitrary value
) (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_awvalid,
  output logic o_awready,
  input wire logic [7:0] i_awaddr,
  input wire logic i_wvalid,
  output logic o_wready,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_wstrb,
  output logic o_bvalid,
  input wire logic i_bready,
  output logic [1:0] o_bresp,
  input wire logic i_arvalid,
  output logic o_arready,
  input wire logic [7:0] i_araddr,
  output logic o_rvalid,
  input wire logic i_rready,
  output logic [31:0] o_rdata,
  output logic [1:0] o_rresp,
  input wire logic i_sync_clock_pin,
  output logic o_sync_clock_pin,
  output logic o_sync_clock_pin_oe,
  input wire logic [ERR_W-1:0] i_error_signal_pin,
  output logic [ERR_W-1:0] o_error_signal_pin,
  output logic o_error_signal_pin_oe,
  output logic [ERR_W-1:0] o_analog_debug_pin,
  output logic o_analog_debug_pin_oe,
  input wire logic [2:0] i_gpio_out,
  input wire logic [2:0] i_gpio_oe,
  output logic [1:0] o_gpio_in,
  input wire logic [ERR_W-1:0] i_ea_code,
  input wire logic [31:0][ERR_W-1:0] i_test_signals,
  output logic [ERR_W-1:0] o_reg_err_code,
  output logic o_sw_clk
);
  if (ERR_W < 1 || ERR_W > 16 || PW < 4 || PW > 16 || OW > PW || OW > 8) begin : g_bad
    $error("multiphase_sync_pin_mux: unsupported widths");
  end

  sync_link_if #(.PW(PW), .OW(OW)) lnk ();
  phase_lock #(.PW(PW), .OW(OW)) u_lock (
    .i_clk_sys(i_clk_sys),
    .i_rst(i_rst),
    .lnk(lnk)
  );

  logic [2:0] role_r;
  logic [4:0] tsel_r;
  logic [OW-1:0] phase_r;
  logic [3:0] gain_r;
  logic bench_r;
  logic [PW-1:0] period_r;
  pin_mux_pkg::role_t role;
  logic aw_got_r, w_got_r, bvalid_r, rvalid_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r, rdata_r, wr_val;
  logic [3:0] w_strb_r;
  logic [1:0] bresp_r, rresp_r;
  logic do_wr, wr_ok, rd_ok;
  logic [31:0] rd_val;
  logic s1_r, s2_r, s3_r;
  logic [ERR_W-1:0] e1_r, e2_r, gained;
  logic [ERR_W+4:0] prod, scaled;
  logic [4:0] mult;

  // Register readback at any word address; ok low when unmapped
  function automatic logic [31:0] reg_read(input logic [7:0] a, output logic ok);
    logic [31:0] v;
    v = 32'h0000_0000;
    ok = 1'b1;
    case ({a[7:2], 2'b00})
      `OFS_BUFCFG: v = (32'(role_r) << `ROLE_LSB) | (32'(tsel_r) << `TSEL_LSB);
      `OFS_PHASE: v = 32'(phase_r);
      `OFS_GAIN: v = 32'(gain_r);
      `OFS_ATEST: v = 32'(bench_r) << `BENCH_BIT;
      `OFS_PERIOD: v = 32'(period_r);
      `OFS_STATUS: v = (32'(lnk.meas_period) << `STAT_MEAS_LSB)
        | (32'(lnk.sw_clk) << `STAT_SWCLK_BIT) | (32'(lnk.locked) << `STAT_LOCK_BIT);
      `OFS_CAL0: v = CAL0_VAL;
      `OFS_CAL1: v = CAL1_VAL;
      default: ok = 1'b0;
    endcase
    return v;
  endfunction : reg_read

  // Byte-lane merge so partial writes keep the other lanes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
      input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        m[8*i +: 8] = nw[8*i +: 8];
      end
    end
    return m;
  endfunction : merge

  // Address and data may come in either order; one write in flight
  assign o_awready = !aw_got_r && !bvalid_r;
  assign o_wready = !w_got_r && !bvalid_r;
  assign do_wr = aw_got_r && w_got_r && !bvalid_r;
  assign o_bvalid = bvalid_r;
  assign o_bresp = bresp_r;
  assign o_arready = !rvalid_r;
  assign o_rvalid = rvalid_r;
  assign o_rdata = rdata_r;
  assign o_rresp = rresp_r;

  // Write merge and read lookup; read flags stay out of the clocked process
  always_comb begin
    rd_ok = 1'b0;
    rd_val = reg_read(i_araddr, rd_ok);
    wr_ok = 1'b0;
    wr_val = merge(reg_read(aw_addr_r, wr_ok), w_data_r, w_strb_r);
    if ({aw_addr_r[7:2], 2'b00} == `OFS_STATUS || {aw_addr_r[7:2], 2'b00} == `OFS_CAL0
        || {aw_addr_r[7:2], 2'b00} == `OFS_CAL1) begin
      wr_ok = 1'b0;
    end
  end

  // Write channel capture and response
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= `RESP_OKAY;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h0000_0000;
      w_strb_r <= 4'h0;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= i_awaddr;
      end
      if (i_wvalid && o_wready) begin
        w_got_r <= 1'b1;
        w_data_r <= i_wdata;
        w_strb_r <= i_wstrb;
      end
      if (do_wr) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
        bvalid_r <= 1'b1;
        bresp_r <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_r && i_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Software-written control registers
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      role_r <= `RST_ROLE;
      tsel_r <= `RST_TSEL;
      phase_r <= OW'(`RST_PHASE);
      gain_r <= `RST_GAIN;
      bench_r <= `RST_BENCH;
      period_r <= PW'(`SW_PERIOD_CYC);
    end else if (do_wr && wr_ok) begin
      case ({aw_addr_r[7:2], 2'b00})
        `OFS_BUFCFG: begin
          role_r <= wr_val[`ROLE_LSB +: 3];
          tsel_r <= wr_val[`TSEL_LSB +: 5];
        end
        `OFS_PHASE: phase_r <= wr_val[OW-1:0];
        `OFS_GAIN: gain_r <= wr_val[3:0];
        `OFS_ATEST: bench_r <= wr_val[`BENCH_BIT];
        `OFS_PERIOD: period_r <= wr_val[PW-1:0];
        default: ;
      endcase
    end
  end

  // Read channel; data held until the master takes it
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= `RESP_OKAY;
    end else if (i_arvalid && o_arready) begin
      rvalid_r <= 1'b1;
      rdata_r <= rd_val;
      rresp_r <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid_r && i_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // Role decode; unused codes fall back to standalone
  always_comb begin
    case (role_r)
      `ROLE_CODE_MP_MASTER: role = pin_mux_pkg::ROLE_MP_MASTER;
      `ROLE_CODE_MP_SLAVE: role = pin_mux_pkg::ROLE_MP_SLAVE;
      `ROLE_CODE_MO_MASTER: role = pin_mux_pkg::ROLE_MO_MASTER;
      `ROLE_CODE_MO_SLAVE: role = pin_mux_pkg::ROLE_MO_SLAVE;
      default: role = pin_mux_pkg::ROLE_STANDALONE;
    endcase
  end

  // Pin synchronisers; the error code is slow analog so bit skew is benign
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      e1_r <= '0;
      e2_r <= '0;
    end else begin
      s1_r <= i_sync_clock_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
      e1_r <= i_error_signal_pin;
      e2_r <= e1_r;
    end
  end
  assign o_gpio_in = {e2_r[0], s2_r};

  // Hand the lock the master edge only in a slave role
  assign lnk.slave_mode = (role == pin_mux_pkg::ROLE_MP_SLAVE)
    || (role == pin_mux_pkg::ROLE_MO_SLAVE);
  assign lnk.master_edge = lnk.slave_mode && s2_r && !s3_r;
  assign lnk.period_cfg = period_r;
  assign lnk.phase_off = phase_r;
  assign o_sw_clk = lnk.sw_clk;

  // Gain in eighths above unity, saturated to the code range
  always_comb begin
    mult = `GAIN_UNITY + 5'(gain_r);
    prod = (ERR_W+5)'(e2_r) * (ERR_W+5)'(mult);
    scaled = prod >> `GAIN_SHIFT;
    gained = (scaled[ERR_W+4:ERR_W] != 5'h00) ? '1 : scaled[ERR_W-1:0];
  end

  // Regulation source: own amplifier unless a multi-phase slave
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_reg_err_code <= '0;
    end else if (role == pin_mux_pkg::ROLE_MP_SLAVE) begin
      o_reg_err_code <= gained;
    end else begin
      o_reg_err_code <= i_ea_code;
    end
  end

  // Sync clock pin function per role
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_sync_clock_pin <= 1'b0;
      o_sync_clock_pin_oe <= 1'b0;
    end else begin
      case (role)
        pin_mux_pkg::ROLE_MP_MASTER, pin_mux_pkg::ROLE_MO_MASTER: begin
          o_sync_clock_pin <= lnk.sw_clk;
          o_sync_clock_pin_oe <= 1'b1;
        end
        pin_mux_pkg::ROLE_MP_SLAVE, pin_mux_pkg::ROLE_MO_SLAVE: begin
          o_sync_clock_pin <= 1'b0;
          o_sync_clock_pin_oe <= 1'b0;
        end
        default: begin
          o_sync_clock_pin <= i_gpio_out[1];
          o_sync_clock_pin_oe <= i_gpio_oe[1];
        end
      endcase
    end
  end

  // Error pin function; plain GPIO in multiple-output roles
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_error_signal_pin <= '0;
      o_error_signal_pin_oe <= 1'b0;
    end else begin
      case (role)
        pin_mux_pkg::ROLE_MP_MASTER: begin
          o_error_signal_pin <= i_ea_code;
          o_error_signal_pin_oe <= 1'b1;
        end
        pin_mux_pkg::ROLE_MP_SLAVE: begin
          o_error_signal_pin <= '0;
          o_error_signal_pin_oe <= 1'b0;
        end
        default: begin
          o_error_signal_pin <= ERR_W'(i_gpio_out[2]);
          o_error_signal_pin_oe <= i_gpio_oe[2];
        end
      endcase
    end
  end

  // Debug pin; bench mode overrides GPIO regardless of role
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_analog_debug_pin <= '0;
      o_analog_debug_pin_oe <= 1'b0;
    end else if (bench_r) begin
      o_analog_debug_pin <= i_test_signals[tsel_r];
      o_analog_debug_pin_oe <= 1'b1;
    end else begin
      o_analog_debug_pin <= ERR_W'(i_gpio_out[0]);
      o_analog_debug_pin_oe <= i_gpio_oe[0];
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  property p_role_decode;
    (role_r == `ROLE_CODE_MO_SLAVE) |-> (role == pin_mux_pkg::ROLE_MO_SLAVE);
  endproperty
  a_role_decode: assert property (p_role_decode)
    else $error("role field decoded wrongly");

  property p_mp_clk_out;
    (role == pin_mux_pkg::ROLE_MP_MASTER) |=>
      (o_sync_clock_pin_oe && o_sync_clock_pin == $past(lnk.sw_clk));
  endproperty
  a_mp_clk_out: assert property (p_mp_clk_out)
    else $error("master clock not on sync pin");

  property p_mp_err_out;
    (role == pin_mux_pkg::ROLE_MP_MASTER) |=>
      (o_error_signal_pin_oe && o_error_signal_pin == $past(i_ea_code));
  endproperty
  a_mp_err_out: assert property (p_mp_err_out)
    else $error("master error not on error pin");

  property p_mp_slave_in;
    (role == pin_mux_pkg::ROLE_MP_SLAVE)[*2] |-> (!o_sync_clock_pin_oe && !o_error_signal_pin_oe);
  endproperty
  a_mp_slave_in: assert property (p_mp_slave_in)
    else $error("slave pins driven");

  property p_slave_gain;
    (role == pin_mux_pkg::ROLE_MP_SLAVE && gain_r == 4'h0) |=> (o_reg_err_code == $past(e2_r));
  endproperty
  a_slave_gain: assert property (p_slave_gain)
    else $error("unity gain error path wrong");

  property p_mo_master;
    (role == pin_mux_pkg::ROLE_MO_MASTER) |=> (o_sync_clock_pin_oe
      && o_error_signal_pin_oe == $past(i_gpio_oe[2]));
  endproperty
  a_mo_master: assert property (p_mo_master)
    else $error("multiple-output master pins wrong");

  property p_mo_slave;
    (role == pin_mux_pkg::ROLE_MO_SLAVE) |=> (!o_sync_clock_pin_oe
      && o_error_signal_pin_oe == $past(i_gpio_oe[2]) && o_reg_err_code == $past(i_ea_code));
  endproperty
  a_mo_slave: assert property (p_mo_slave)
    else $error("multiple-output slave pins wrong");

  property p_bench;
    bench_r |=> (o_analog_debug_pin_oe
      && o_analog_debug_pin == $past(i_test_signals[tsel_r]));
  endproperty
  a_bench: assert property (p_bench)
    else $error("bench signal not on debug pin");

  property p_cal_protect;
    (do_wr && {aw_addr_r[7:2], 2'b00} == `OFS_CAL0) |=> (o_bresp == `RESP_SLVERR && o_bvalid);
  endproperty
  a_cal_protect: assert property (p_cal_protect)
    else $error("calibration write accepted");

  property p_standalone;
    (role == pin_mux_pkg::ROLE_STANDALONE) |=> (o_sync_clock_pin == $past(i_gpio_out[1])
      && o_sync_clock_pin_oe == $past(i_gpio_oe[1]));
  endproperty
  a_standalone: assert property (p_standalone)
    else $error("standalone sync pin not GPIO");
endmodule : multiphase_sync_pin_mux

// ---- bench/conv_partner.sv ----
// Behavioural far-side converter acting as master: sync clock and error code
`timescale 1ns/1ps
module conv_partner (
  input wire logic i_en,
  input wire logic [9:0] i_err_code,
  output logic o_sync_clk,
  output logic [9:0] o_err
);
  // Clock of 200 ns while enabled, standing low otherwise; offset off the sys edges
  initial begin
    o_sync_clk = 1'b0;
    #7;
    forever begin
      #100;
      o_sync_clk = i_en ? ~o_sync_clk : 1'b0;
    end
  end
  // Released error line toggles so a stale code never reads back as valid
  initial begin
    o_err = 10'h000;
    forever begin
      #25;
      o_err = i_en ? i_err_code : ~o_err;
    end
  end
endmodule : conv_partner

// ---- bench/multiphase_sync_pin_mux_test.sv ----
// Register-level bench for the multiphase pin mux
`timescale 1ns/1ps
`include "pin_mux_params.svh"
module multiphase_sync_pin_mux_test;
  localparam logic [31:0] CAL0_V = 32'h0000_a5a5; // Arbitrary value
  localparam logic [31:0] CAL1_V = 32'h0000_3c3c; // Arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic awvalid, wvalid, bready, arvalid, rready, p_en, p_clk, sw_p;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [2:0] gpio_out, gpio_oe;
  logic [9:0] ea_code, err_code, p_err, err_w, err_o, reg_err, dbg;
  logic [31:0][9:0] tsig;
  logic awready, wready, bvalid, arready, rvalid, sync_o, sync_oe, err_oe, dbg_oe, sw_clk;
  logic [1:0] bresp, rresp, gpio_in;
  int n_fail = 0;
  int total_checks = 0;
  int cyc = 0;
  int d0, d2, e;
  logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h1c, 8'h20};
  logic [31:0] rst_v [8] = '{0, 0, 0, 0, 133, CAL0_V, CAL1_V, 0};
  int gv [4] = '{0, 8, 15, 8};
  int cv [4] = '{100, 100, 100, 600};
  wire sync_w = sync_oe ? sync_o : p_clk;
  assign err_w = err_oe ? err_o : p_err;

  always #12.5 clk = ~clk;

  multiphase_sync_pin_mux #(.CAL0_VAL(CAL0_V), .CAL1_VAL(CAL1_V)) u_dut (
    .i_clk_sys(clk), .i_rst(rst), .i_awvalid(awvalid), .o_awready(awready),
    .i_awaddr(awaddr), .i_wvalid(wvalid), .o_wready(wready), .i_wdata(wdata),
    .i_wstrb(wstrb), .o_bvalid(bvalid), .i_bready(bready), .o_bresp(bresp),
    .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr), .o_rvalid(rvalid),
    .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .i_sync_clock_pin(sync_w),
    .o_sync_clock_pin(sync_o), .o_sync_clock_pin_oe(sync_oe), .i_error_signal_pin(err_w),
    .o_error_signal_pin(err_o), .o_error_signal_pin_oe(err_oe), .o_analog_debug_pin(dbg),
    .o_analog_debug_pin_oe(dbg_oe), .i_gpio_out(gpio_out), .i_gpio_oe(gpio_oe),
    .o_gpio_in(gpio_in), .i_ea_code(ea_code), .i_test_signals(tsig),
    .o_reg_err_code(reg_err), .o_sw_clk(sw_clk));

  conv_partner u_partner (.i_en(p_en), .i_err_code(err_code), .o_sync_clk(p_clk), .o_err(p_err));

  task automatic results();
    $display("checks %0d, mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results

  // Hang guard well beyond the planned sequence
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_fail++;
      results();
    end
  end

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk); // Compare away from the edge that launches outputs
  endtask : idle

  // Both channels offered together, each released after its own handshake edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    int k;
    @(posedge clk);
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= d;
    wstrb <= 4'hf;
    bready <= 1'b1;
    b_t = 1'b0;
    for (k = 0; k < 50 && !b_t; k++) begin
      @(negedge clk);
      aw_t = awvalid && awready;
      w_t = wvalid && wready;
      b_t = bvalid === 1'b1;
      if (b_t) chk("bresp", 32'(er), 32'(bresp));
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    if (!b_t) chk("bvalid", 32'h1, 32'h0);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ex, input logic [31:0] m,
      input logic [1:0] er);
    logic ar_t, r_t;
    int k;
    @(posedge clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    r_t = 1'b0;
    for (k = 0; k < 50 && !r_t; k++) begin
      @(negedge clk);
      ar_t = arvalid && arready;
      r_t = rvalid === 1'b1;
      if (r_t) chk("rdata", ex, rdata & m);
      if (r_t) chk("rresp", 32'(er), 32'(rresp));
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    if (!r_t) chk("rvalid", 32'h1, 32'h0);
  endtask : axi_rd

  // Cycles from a master clock rise to the next local switching rise
  task automatic lag(output int d);
    logic p;
    @(posedge p_clk);
    @(negedge clk);
    d = 0;
    p = sw_clk;
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      if (d == 0 && sw_clk && !p) d = i + 1;
      p = sw_clk;
    end
  endtask : lag

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, p_en} = '0;
    {awaddr, araddr, wdata, wstrb, gpio_out, gpio_oe} = '0;
    ea_code = 10'h155;
    err_code = 10'h000;
    for (int i = 0; i < 32; i++) tsig[i] = 10'(i * 7 + 3);
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    // Reset values, read-only words and an unmapped hole
    for (int i = 0; i < 8; i++) axi_rd(ofs[i], rst_v[i], '1, i == 7 ? 2'h2 : 2'h0);
    axi_wr(`OFS_CAL0, 32'hffff_ffff, `RESP_SLVERR);
    axi_rd(`OFS_CAL0, CAL0_V, '1, `RESP_OKAY);
    // Pin claim per role code, spare code included
    for (int r = 0; r < 6; r++) begin
      axi_wr(`OFS_BUFCFG, 32'(r), `RESP_OKAY);
      idle(4);
      chk("sync_oe", 32'(r == 1 || r == 3), 32'(sync_oe));
      chk("err_oe", 32'(r == 1), 32'(err_oe));
    end
    // Short period so the switching clock toggles inside the window
    axi_wr(`OFS_PERIOD, 32'h8, `RESP_OKAY);
    for (int m = 1; m < 4; m += 2) begin
      axi_wr(`OFS_BUFCFG, 32'(m), `RESP_OKAY);
      idle(4);
      @(negedge clk);
      for (int i = 0; i < 16; i++) begin
        sw_p = sw_clk;
        @(negedge clk);
        chk("sync_pin", 32'(sw_p), 32'(sync_o));
      end
      chk("err_oe", 32'(m == 1), 32'(err_oe));
      if (m == 1) chk("err_pin", 32'(ea_code), 32'(err_o));
    end
    // Multi-phase slave fed by the partner master
    p_en <= 1'b1;
    axi_wr(`OFS_BUFCFG, 32'(`ROLE_CODE_MP_SLAVE), `RESP_OKAY);
    idle(60);
    axi_rd(`OFS_STATUS, 32'h0008_0001, 32'hffff_0001, `RESP_OKAY);
    chk("err_oe", 32'h0, 32'(err_oe));
    axi_wr(`OFS_PHASE, 32'h0, `RESP_OKAY);
    idle(20);
    lag(d0);
    axi_wr(`OFS_PHASE, 32'h2, `RESP_OKAY);
    idle(20);
    lag(d2);
    chk("phase_lag", 32'(d0 + 2), 32'(d2));
    for (int i = 0; i < 4; i++) begin
      err_code <= 10'(cv[i]);
      axi_wr(`OFS_GAIN, 32'(gv[i]), `RESP_OKAY);
      idle(8);
      e = cv[i] * (8 + gv[i]) / 8;
      if (e > 1023) e = 1023;
      chk("reg_err", 32'(e), 32'(reg_err));
    end
    // Multiple-output slave: clock locked, own amplifier regulates
    axi_wr(`OFS_BUFCFG, 32'(`ROLE_CODE_MO_SLAVE), `RESP_OKAY);
    idle(60);
    axi_rd(`OFS_STATUS, 32'h0008_0001, 32'hffff_0001, `RESP_OKAY);
    chk("reg_err", 32'(ea_code), 32'(reg_err));
    chk("err_oe", 32'h0, 32'(err_oe));
    p_en <= 1'b0;
    // Bench test: every select code reaches the debug pin
    axi_wr(`OFS_ATEST, 32'h1, `RESP_OKAY);
    for (int s = 0; s < 32; s++) begin
      axi_wr(`OFS_BUFCFG, 32'(s) << `TSEL_LSB, `RESP_OKAY);
      idle(3);
      chk("dbg_pin", 32'(tsig[s]), 32'(dbg));
      chk("dbg_oe", 32'h1, 32'(dbg_oe));
    end
    axi_wr(`OFS_CAL1, 32'h0, `RESP_SLVERR);
    axi_rd(`OFS_CAL1, CAL1_V, '1, `RESP_OKAY);
    axi_wr(`OFS_ATEST, 32'h0, `RESP_OKAY);
    idle(3);
    chk("dbg_oe", 32'h0, 32'(dbg_oe));
    // Standalone: pins behave as plain GPIO
    @(posedge clk);
    gpio_oe <= 3'b111;
    gpio_out <= 3'b111;
    idle(4);
    chk("sync_oe", 32'h1, 32'(sync_oe));
    chk("sync_pin", 32'h1, 32'(sync_o));
    chk("err_oe", 32'h1, 32'(err_oe));
    chk("dbg_pin", 32'h1, 32'(dbg));
    chk("gpio_in", 32'h3, 32'(gpio_in));
    results();
  end
endmodule : multiphase_sync_pin_mux_test
